// ==== logic/irq_pkg.sv ====
/*
 holds register offsets, field positions, reset values and mode codes
 for the transceiver interrupt collection logic.
 assumes an apb slave with 32-bit data and byte offsets = 4 x index.
*/
// Notes on behaviour
// - status bit reads 1 if its source fired since the last read
// - reading status clears it, except level-mode sources still present
// - masked status bits always read zero
// - status and mask registers reset to zero
// - transmitter slip sets on each dropped or repeated sample
// - block-start arrival sets transmitter slip when that pin is an input
// - output port slip sets in slave mode on dropped or repeated sample
// - channel-status d-to-e completion sets its bit
// - channel-status e-to-f completion sets its bit
// - receiver error sets its bit; cause is in the receiver error register
// - user d-to-e completion sets its bit in block mode only
// - user e-to-f completion sets its bit in block mode only
// - mask 1 passes source to status and pin; 0 blocks both
// - mode code upper bit from high register, lower from low register
// - code 00 rising, 01 falling, 10 level, 11 reserved
// - rising mode: pin asserts when condition appears
// - falling mode: pin asserts when condition goes away
// - level mode: pin active while condition persists
// - pin polarity set only by the output type field
// - mode registers reset to zero, every source rising-edge
// - output type 10 is open-drain active low; 11 reserved
// - only unmasked receiver errors raise the receiver error source
package irq_pkg;
   // register indices, byte address is four times the index
   localparam logic [7:0] IDX_CONTROL     = 8'h01;
   localparam logic [7:0] IDX_STATUS_ONE  = 8'h07;
   localparam logic [7:0] IDX_STATUS_TWO  = 8'h08;
   localparam logic [7:0] IDX_MASK_ONE    = 8'h09;
   localparam logic [7:0] IDX_MODE_ONE_HI = 8'h0a;
   localparam logic [7:0] IDX_MODE_ONE_LO = 8'h0b;
   localparam logic [7:0] IDX_MASK_TWO    = 8'h0c;
   localparam logic [7:0] IDX_MODE_TWO_HI = 8'h0d;
   localparam logic [7:0] IDX_MODE_TWO_LO = 8'h0e;
   localparam logic [7:0] IDX_RX_ERR_MASK = 8'h11;
   localparam logic [7:0] IDX_USER_CTRL   = 8'h13;
   localparam logic [7:0] IDX_TXBLK_DIR   = 8'h20;
   // implemented bits per register and the zero reset value
   localparam logic [7:0] USED_ONE        = 8'hc7;
   localparam logic [7:0] USED_TWO        = 8'h0e;
   localparam logic [7:0] USED_RX_ERR     = 8'h7f;
   localparam logic [7:0] RESET_ZERO      = 8'h00;
   // field positions
   localparam int BIT_TX_SLIP  = 7;
   localparam int BIT_OUT_SLIP = 6;
   localparam int BIT_CS_DE    = 2;
   localparam int BIT_CS_EF    = 1;
   localparam int BIT_RX_ERR   = 0;
   localparam int BIT_UD_DE    = 3;
   localparam int BIT_UD_EF    = 2;
   localparam int BIT_SUBCODE  = 1;
   localparam int INT_TYPE_LSB = 1;
   localparam int UBM_LSB      = 2;
   // interrupt output type codes and the user bit manager block mode code
   localparam logic [1:0] INT_ACTIVE_HIGH = 2'h0;
   localparam logic [1:0] INT_ACTIVE_LOW  = 2'h1;
   localparam logic [1:0] INT_OPEN_DRAIN  = 2'h2;
   localparam logic [1:0] UBM_BLOCK       = 2'h1;
   // per-source trigger modes
   typedef enum logic [1:0] {
      MODE_RISE  = 2'h0,
      MODE_FALL  = 2'h1,
      MODE_LEVEL = 2'h2,
      MODE_RSVD  = 2'h3
   } irq_mode_t;
   localparam int SUBCODE_FRAMES = 588;
endpackage

// ==== logic/transceiver_interrupt_logic.sv ====
/*
 interrupt status, mask and mode registers with apb access and the pin.
 assumes source inputs are synchronous one-bit condition levels.
*/
`timescale 1ns/1ps
`default_nettype none
module transceiver_interrupt_logic
   import irq_pkg::*;
(
   // clock and reset
   input  wire logic        clock_in,
   input  wire logic        rst_n_in,
   // apb slave
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [11:0] paddr_in,
   input  wire logic [31:0] pwdata_in,
   output var  logic [31:0] prdata_out,
   output var  logic        pready_out,
   output var  logic        pslverr_out,
   // source conditions
   input  wire logic        tx_slip_in,
   input  wire logic        tx_block_start_pin_in,
   input  wire logic        out_slip_in,
   input  wire logic        out_port_slave_in,
   input  wire logic        cs_d_to_e_in,
   input  wire logic        cs_e_to_f_in,
   input  wire logic [6:0]  rx_error_in,
   input  wire logic        ud_d_to_e_in,
   input  wire logic        ud_e_to_f_in,
   input  wire logic        subcode_block_in,
   // interrupt pin
   output var  logic        int_pin_out,
   output var  logic        int_pin_oe_n_out
);
   // stored status, one register per group
   logic [7:0] status_one_q;
   logic [7:0] status_two_q;

   // source masks; 1 lets a source through
   logic [7:0] mask_one_q;
   logic [7:0] mask_two_q;

   // mode code halves per source
   logic [7:0] mode_one_hi_q;
   logic [7:0] mode_one_lo_q;
   logic [7:0] mode_two_hi_q;
   logic [7:0] mode_two_lo_q;

   // settings the sources and the pin depend on
   logic [7:0] rx_err_mask_q;
   logic [1:0] int_type_q;
   logic [1:0] ubm_q;
   logic       txblk_out_q;

   // source conditions now and one cycle ago
   logic [7:0] src_one;
   logic [7:0] src_two;
   logic [7:0] src_one_q;
   logic [7:0] src_two_q;

   // masked triggers and live level sources
   logic [7:0] trig_one;
   logic [7:0] trig_two;
   logic [7:0] lvl_one;
   logic [7:0] lvl_two;

   // bus decode and read-clear masks
   logic [7:0] rd_data;
   logic       access;
   logic       wr;
   logic       rd;
   logic [7:0] idx;
   logic [7:0] seen_one;
   logic [7:0] seen_two;

   // any pending event
   logic       pend;

   // per-bit trigger for one register given modes and previous source
   // a reserved code stays silent, so a stray write cannot hold the pin
   function automatic logic [7:0] trigger(input logic [7:0] hi, input logic [7:0] lo,
                                          input logic [7:0] now, input logic [7:0] was);
      logic [7:0] t;
      t = 8'h00;
      for (int i = 0; i < 8; i++) begin
         case (irq_mode_t'({hi[i], lo[i]}))
            MODE_RISE: begin
               // condition high now, low one cycle ago
               t[i] = now[i] & ~was[i];
            end
            MODE_FALL: begin
               // condition low now, high one cycle ago
               t[i] = ~now[i] & was[i];
            end
            MODE_LEVEL: begin
               // fires every cycle the condition stands
               t[i] = now[i];
            end
            default: begin
               t[i] = 1'b0; // reserved code never triggers
            end
         endcase
      end
      return t;
   endfunction

   // level-mode mask of a register: upper bit set, lower bit clear
   function automatic logic [7:0] level_bits(input logic [7:0] hi, input logic [7:0] lo);
      return hi & ~lo;
   endfunction

   // unmapped index raises pslverr
   function automatic logic mapped(input logic [7:0] i);
      return i == IDX_STATUS_ONE || i == IDX_STATUS_TWO || i == IDX_MASK_ONE ||
             i == IDX_MASK_TWO || i == IDX_MODE_ONE_HI || i == IDX_MODE_ONE_LO ||
             i == IDX_MODE_TWO_HI || i == IDX_MODE_TWO_LO || i == IDX_RX_ERR_MASK ||
             i == IDX_CONTROL || i == IDX_USER_CTRL || i == IDX_TXBLK_DIR;
   endfunction

   // write strobe for one register index
   function automatic logic wr_hit(input logic [7:0] i);
      return wr && (idx == i);
   endfunction

   // apb decode; the answer is registered, so no wait states
   assign access = psel_in & penable_in;
   assign wr     = access & pwrite_in;
   assign rd     = access & ~pwrite_in;
   // upper address bits are not decoded: the map repeats
   assign idx    = paddr_in[9:2];

   // source conditions gathered into register layout
   // unused positions stay zero so they never set a status bit
   always_comb begin
      src_one = 8'h00;
      src_two = 8'h00;
      // block-start arrivals count only while that pin is an input
      src_one[BIT_TX_SLIP]  = tx_slip_in | (~txblk_out_q & tx_block_start_pin_in);
      // output port slips only matter while the port is a slave
      src_one[BIT_OUT_SLIP] = out_port_slave_in & out_slip_in;
      src_one[BIT_CS_DE]    = cs_d_to_e_in;
      src_one[BIT_CS_EF]    = cs_e_to_f_in;
      // receiver errors count only where their own mask allows
      src_one[BIT_RX_ERR]   = |(rx_error_in & rx_err_mask_q[6:0]);
      // user buffer transfers only exist in block mode
      src_two[BIT_UD_DE]    = (ubm_q == UBM_BLOCK) & ud_d_to_e_in;
      src_two[BIT_UD_EF]    = (ubm_q == UBM_BLOCK) & ud_e_to_f_in;
      src_two[BIT_SUBCODE]  = subcode_block_in; // host must drain it in time
   end

   // a blocked source reaches neither status nor pin
   assign trig_one = trigger(mode_one_hi_q, mode_one_lo_q, src_one, src_one_q) & mask_one_q;
   assign trig_two = trigger(mode_two_hi_q, mode_two_lo_q, src_two, src_two_q) & mask_two_q;
   // level sources still present survive a read
   assign lvl_one  = level_bits(mode_one_hi_q, mode_one_lo_q) & src_one & mask_one_q;
   assign lvl_two  = level_bits(mode_two_hi_q, mode_two_lo_q) & src_two & mask_two_q;

   // previous first-group sources for edge detection
   // reset to the idle level zero, so no false edge follows reset
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         src_one_q <= RESET_ZERO;
      end else begin
         src_one_q <= src_one;
      end
   end

   // previous second-group sources for edge detection
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         src_two_q <= RESET_ZERO;
      end else begin
         src_two_q <= src_two;
      end
   end

   // bits the host was shown in this read; only those are cleared,
   // so an event landing between setup and access is not lost
   assign seen_one = (rd && idx == IDX_STATUS_ONE) ? prdata_out[7:0] : RESET_ZERO;
   assign seen_two = (rd && idx == IDX_STATUS_TWO) ? prdata_out[7:0] : RESET_ZERO;

   // first status group; a set in the read cycle wins over the clear
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         status_one_q <= RESET_ZERO;
      end else begin
         status_one_q <= ((status_one_q & ~seen_one) | trig_one | lvl_one)
                         & mask_one_q & USED_ONE;
      end
   end

   // second status group, same rules
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         status_two_q <= RESET_ZERO;
      end else begin
         status_two_q <= ((status_two_q & ~seen_two) | trig_two | lvl_two)
                         & mask_two_q & USED_TWO;
      end
   end

   // first mask; a 1 lets its source reach status and pin
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mask_one_q <= RESET_ZERO;
      end else if (wr_hit(IDX_MASK_ONE)) begin
         mask_one_q <= pwdata_in[7:0] & USED_ONE;
      end
   end

   // second mask
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mask_two_q <= RESET_ZERO;
      end else if (wr_hit(IDX_MASK_TWO)) begin
         mask_two_q <= pwdata_in[7:0] & USED_TWO;
      end
   end

   // first group mode, upper bits
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mode_one_hi_q <= RESET_ZERO;
      end else if (wr_hit(IDX_MODE_ONE_HI)) begin
         mode_one_hi_q <= pwdata_in[7:0] & USED_ONE;
      end
   end

   // first group mode, lower bits
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mode_one_lo_q <= RESET_ZERO;
      end else if (wr_hit(IDX_MODE_ONE_LO)) begin
         mode_one_lo_q <= pwdata_in[7:0] & USED_ONE;
      end
   end

   // second group mode, upper bits
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mode_two_hi_q <= RESET_ZERO;
      end else if (wr_hit(IDX_MODE_TWO_HI)) begin
         mode_two_hi_q <= pwdata_in[7:0] & USED_TWO;
      end
   end

   // second group mode, lower bits
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mode_two_lo_q <= RESET_ZERO;
      end else if (wr_hit(IDX_MODE_TWO_LO)) begin
         mode_two_lo_q <= pwdata_in[7:0] & USED_TWO;
      end
   end

   // receiver error mask; a cleared bit hides that error
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rx_err_mask_q <= RESET_ZERO;
      end else if (wr_hit(IDX_RX_ERR_MASK)) begin
         rx_err_mask_q <= pwdata_in[7:0] & USED_RX_ERR;
      end
   end

   // pin output type; starts driven active high
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         int_type_q <= INT_ACTIVE_HIGH;
      end else if (wr_hit(IDX_CONTROL)) begin
         int_type_q <= pwdata_in[INT_TYPE_LSB +: 2];
      end
   end

   // user bit manager mode
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ubm_q <= RESET_ZERO[1:0];
      end else if (wr_hit(IDX_USER_CTRL)) begin
         ubm_q <= pwdata_in[UBM_LSB +: 2];
      end
   end

   // block-start pin direction; starts as an input
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         txblk_out_q <= 1'b0;
      end else if (wr_hit(IDX_TXBLK_DIR)) begin
         txblk_out_q <= pwdata_in[0];
      end
   end

   // read multiplexer; unmapped indices read zero
   always_comb begin
      case (idx)
         IDX_STATUS_ONE:  rd_data = status_one_q;
         IDX_STATUS_TWO:  rd_data = status_two_q;
         IDX_MASK_ONE:    rd_data = mask_one_q;
         IDX_MASK_TWO:    rd_data = mask_two_q;
         IDX_MODE_ONE_HI: rd_data = mode_one_hi_q;
         IDX_MODE_ONE_LO: rd_data = mode_one_lo_q;
         IDX_MODE_TWO_HI: rd_data = mode_two_hi_q;
         IDX_MODE_TWO_LO: rd_data = mode_two_lo_q;
         IDX_RX_ERR_MASK: rd_data = rx_err_mask_q;
         IDX_CONTROL:     rd_data = {5'h00, int_type_q, 1'b0};
         IDX_USER_CTRL:   rd_data = {4'h0, ubm_q, 2'h0};
         IDX_TXBLK_DIR:   rd_data = {7'h00, txblk_out_q};
         default:         rd_data = 8'h00;
      endcase
   end

   // pready one cycle after setup, so the access never waits
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pready_out <= 1'b0;
      end else begin
         pready_out <= psel_in & ~penable_in;
      end
   end

   // error answer for an unmapped index, paired with pready
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pslverr_out <= 1'b0;
      end else begin
         pslverr_out <= psel_in & ~penable_in & ~mapped(idx);
      end
   end

   // read data captured at setup; the clear uses this same value
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         prdata_out <= 32'h0000_0000;
      end else if (psel_in & ~penable_in & ~pwrite_in) begin
         prdata_out <= {24'h00_0000, rd_data};
      end else begin
         prdata_out <= 32'h0000_0000;
      end
   end

   // pending events drive the pin; polarity only from the type field
   assign pend = |status_one_q | |status_two_q;

   // pin follows status one edge later; a read clear drops it next edge
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         int_pin_out      <= 1'b0;
         int_pin_oe_n_out <= 1'b0;
      end else begin
         case (int_type_q)
            INT_ACTIVE_HIGH: begin
               int_pin_out      <= pend;
               int_pin_oe_n_out <= 1'b0;
            end

            INT_ACTIVE_LOW: begin
               int_pin_out      <= ~pend;
               int_pin_oe_n_out <= 1'b0;
            end

            INT_OPEN_DRAIN: begin
               int_pin_out      <= 1'b0;
               int_pin_oe_n_out <= ~pend; // released when idle, pull-up lifts it
            end

            // reserved type lets the line float to its pull-up
            default: begin
               int_pin_out      <= 1'b0; // reserved type: pin released
               int_pin_oe_n_out <= 1'b1;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// ==== verification/host_irq_model.sv ====
/*
 host side of the interrupt pin: the wire and its pull-up.
 assumes pin data and an active-low drive enable from the block.
*/
`timescale 1ns/1ps
`default_nettype none
module host_irq_model (
   // pin from the device
   input  wire logic pin_data_in,
   input  wire logic pin_oe_n_in,
   // level the host sees
   output var  logic pin_level_out
);
   // released pin floats up, so open drain reads high when idle
   always_comb pin_level_out = pin_oe_n_in ? 1'b1 : pin_data_in;
endmodule
`default_nettype wire

// ==== verification/irq_monitor.sv ====
/*
 port checker for the interrupt collection block.
 assumes it is bound to the block top and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module irq_monitor
   import irq_pkg::*;
(
   // clock, reset and apb
   input wire logic        clock_in,
   input wire logic        rst_n_in,
   input wire logic        psel_in,
   input wire logic        penable_in,
   input wire logic        pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [31:0] prdata_out,
   input wire logic        pready_out,
   input wire logic        pslverr_out,
   // sources and pin
   input wire logic        tx_slip_in,
   input wire logic        out_slip_in,
   input wire logic        out_port_slave_in,
   input wire logic        cs_d_to_e_in,
   input wire logic        int_pin_out,
   input wire logic        int_pin_oe_n_out
);
   logic [7:0] mask_q;
   logic [7:0] hi_q;
   logic [7:0] lo_q;
   logic [1:0] type_q;
   wire logic       done = psel_in && penable_in && pready_out;
   wire logic [7:0] idx  = paddr_in[9:2];
   // shadow of the registers the pin checks depend on
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mask_q <= 8'h00;
         hi_q   <= 8'h00;
         lo_q   <= 8'h00;
         type_q <= 2'h0;
      end else if (done && pwrite_in) begin
         if (idx == IDX_MASK_ONE) mask_q <= pwdata_in[7:0];
         if (idx == IDX_MODE_ONE_HI) hi_q <= pwdata_in[7:0];
         if (idx == IDX_MODE_ONE_LO) lo_q <= pwdata_in[7:0];
         if (idx == IDX_CONTROL) type_q <= pwdata_in[2:1];
      end
   end
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);
   a_setup_answer: assert property (psel_in && !penable_in |=> pready_out)
      else $error("no answer after setup");
   a_pready_single: assert property (pready_out |=> !pready_out)
      else $error("pready longer than one cycle");
   a_upper_zero: assert property (pready_out |-> prdata_out[31:8] == 24'h00_0000)
      else $error("upper read bits not zero");
   a_unmapped_zero: assert property (pslverr_out |-> pready_out && prdata_out == 32'h0000_0000)
      else $error("error answer carries data");
   a_reset_quiet: assert property (disable iff (1'b0) !rst_n_in |->
      !pready_out && !pslverr_out && !int_pin_out && prdata_out == 32'h0000_0000)
      else $error("outputs active in reset");
   a_masked_zero: assert property (done && !pwrite_in && idx == IDX_STATUS_ONE
      && mask_q == 8'h00 |-> prdata_out == 32'h0000_0000) else $error("masked status set");
   a_rise_pin: assert property ($rose(tx_slip_in) && mask_q[7] && !hi_q[7] && !lo_q[7]
      && type_q == INT_ACTIVE_HIGH |-> ##[1:3] int_pin_out) else $error("rise missed");
   a_fall_pin: assert property ($fell(out_slip_in) && out_port_slave_in && mask_q[6]
      && lo_q[6] && !hi_q[6] && type_q == INT_ACTIVE_HIGH |-> ##[1:3] int_pin_out)
      else $error("fall missed");
   a_level_pin: assert property (cs_d_to_e_in [*4] ##0 (mask_q[2] && hi_q[2]
      && !lo_q[2] && type_q == INT_ACTIVE_HIGH) |-> int_pin_out) else $error("level missed");
   a_open_drain: assert property ($rose(tx_slip_in) && mask_q[7] && !hi_q[7] && !lo_q[7]
      && type_q == INT_OPEN_DRAIN |-> ##[1:3] !int_pin_oe_n_out && !int_pin_out)
      else $error("open drain not pulled low");
endmodule
`default_nettype wire

// ==== verification/tb_transceiver_interrupt_logic.sv ====
/*
 top bench: apb reads and writes against expected register values.
 assumes the block, its package, the checker and the host model.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_transceiver_interrupt_logic
   import irq_pkg::*;
();
   logic        clock_in = 1'b0;
   logic        rst_n_in = 1'b1;
   logic        psel_in = 1'b0;
   logic        penable_in = 1'b0;
   logic        pwrite_in = 1'b0;
   logic [11:0] paddr_in = 12'h000;
   logic [31:0] pwdata_in = 32'h0000_0000;
   logic [31:0] prdata_out;
   logic        pready_out;
   logic        pslverr_out;
   logic        int_pin_out;
   logic        int_pin_oe_n_out;
   logic        pin_level;
   logic [15:0] src = 16'h0000;
   logic [31:0] rd;
   logic        er;
   int          num_errors = 0;
   int          cmp_count = 0;
   int          cycles = 0;
   always #25 clock_in = ~clock_in;
   // sources 0..8 single bits, receiver errors in 15:9
   transceiver_interrupt_logic dut (.clock_in, .rst_n_in, .psel_in, .penable_in,
      .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
      .tx_slip_in(src[0]), .tx_block_start_pin_in(src[1]), .out_slip_in(src[2]),
      .out_port_slave_in(src[3]), .cs_d_to_e_in(src[4]), .cs_e_to_f_in(src[5]),
      .rx_error_in(src[15:9]), .ud_d_to_e_in(src[6]), .ud_e_to_f_in(src[7]),
      .subcode_block_in(src[8]), .int_pin_out, .int_pin_oe_n_out);
   host_irq_model host (.pin_data_in(int_pin_out), .pin_oe_n_in(int_pin_oe_n_out),
      .pin_level_out(pin_level));
   // one apb transfer, waiting on pready; idle cycle after it
   task apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
      psel_in <= 1'b1;
      pwrite_in <= w;
      paddr_in <= {2'b00, idx, 2'b00};
      pwdata_in <= {24'h00_0000, d};
      @(posedge clock_in);
      penable_in <= 1'b1;
      do @(posedge clock_in); while (pready_out !== 1'b1);
      rd = prdata_out;
      er = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
      @(posedge clock_in);
   endtask
   task chk(input logic [7:0] idx, input logic [7:0] exp, input logic exp_er);
      apb(1'b0, idx, 8'h00);
      cmp_count++;
      if (rd !== {24'h00_0000, exp} || er !== exp_er) begin
         num_errors++;
         $display("CHECK FAILED reg %h expected %h/%b seen %h/%b", idx, exp, exp_er, rd, er);
      end
   endtask
   // pin sampled mid-cycle, clear of the edge updates
   task pin(input logic exp);
      @(negedge clock_in);
      cmp_count++;
      if (pin_level !== exp) begin
         num_errors++;
         $display("CHECK FAILED pin expected %b seen %b", exp, pin_level);
      end
      @(posedge clock_in);
   endtask
   task pulse(input int b);
      src[b] <= 1'b1;
      @(posedge clock_in);
      src[b] <= 1'b0;
      repeat (3) @(posedge clock_in);
   endtask
   task report_and_stop;
      $display("errors %0d checks %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // hang guard, far above the roughly 175 cycles needed
   always @(posedge clock_in) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         report_and_stop;
      end
   end
   initial begin
      rst_n_in <= 1'b0;
      repeat (4) @(posedge clock_in);
      rst_n_in <= 1'b1;
      src[3] <= 1'b1;
      @(posedge clock_in);
      for (int i = 7; i < 15; i++) chk(8'(i), 8'h00, 1'b0);
      chk(8'h05, 8'h00, 1'b1);
      pulse(0);
      chk(8'h07, 8'h00, 1'b0);
      apb(1'b1, 8'h09, 8'hff);
      chk(8'h09, 8'hc7, 1'b0);
      apb(1'b1, 8'h0c, 8'hff);
      chk(8'h0c, 8'h0e, 1'b0);
      pulse(0);
      pin(1'b1);
      chk(8'h07, 8'h80, 1'b0);
      chk(8'h07, 8'h00, 1'b0);
      pin(1'b0);
      pulse(1);
      chk(8'h07, 8'h80, 1'b0);
      apb(1'b1, 8'h0b, 8'h40);
      src[2] <= 1'b1;
      repeat (3) @(posedge clock_in);
      chk(8'h07, 8'h00, 1'b0);
      src[2] <= 1'b0;
      repeat (3) @(posedge clock_in);
      pin(1'b1);
      chk(8'h07, 8'h40, 1'b0);
      apb(1'b1, 8'h0a, 8'h04);
      src[4] <= 1'b1;
      repeat (5) @(posedge clock_in);
      pin(1'b1);
      chk(8'h07, 8'h04, 1'b0);
      chk(8'h07, 8'h04, 1'b0);
      src[4] <= 1'b0;
      repeat (3) @(posedge clock_in);
      chk(8'h07, 8'h04, 1'b0);
      chk(8'h07, 8'h00, 1'b0);
      pulse(5);
      chk(8'h07, 8'h02, 1'b0);
      pulse(12);
      chk(8'h07, 8'h00, 1'b0);
      apb(1'b1, 8'h11, 8'h08);
      pulse(12);
      chk(8'h07, 8'h01, 1'b0);
      pulse(6);
      chk(8'h08, 8'h00, 1'b0);
      apb(1'b1, 8'h13, 8'h04);
      pulse(6);
      pulse(7);
      pulse(8);
      chk(8'h08, 8'h0e, 1'b0);
      apb(1'b1, 8'h01, 8'h04);
      pulse(0);
      pin(1'b0);
      chk(8'h07, 8'h80, 1'b0);
      pin(1'b1);
      apb(1'b1, 8'h01, 8'h02);
      pin(1'b1);
      report_and_stop;
   end
endmodule
bind transceiver_interrupt_logic irq_monitor mon (.clock_in, .rst_n_in, .psel_in,
   .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
   .tx_slip_in, .out_slip_in, .out_port_slave_in, .cs_d_to_e_in, .int_pin_out,
   .int_pin_oe_n_out);
`default_nettype wire
